/* design/psa_params.svh */
/*
 * Constants of the program space access unit: field positions, widths,
 * flash geometry, unlock key values and stall counts.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef PSA_PARAMS_SVH
`define PSA_PARAMS_SVH

`define PSA_PADDR_W        24
`define PSA_PAGE_W         8
`define PSA_CFG_BIT        7
`define PSA_REMAP_BIT      15
`define PSA_VIS_EN_BIT     2
`define PSA_ROW_WORDS      64
`define PSA_ROW_IDX_W      6
`define PSA_ROW_BYTES      192
`define PSA_BLOCK_ROWS     8
`define PSA_BLOCK_BYTES    1536
`define PSA_KEY_FIRST      8'h55
`define PSA_KEY_SECOND     8'hAA
`define PSA_START_BIT      15
`define PSA_FILL_WORD      24'hFFFFFF
`define PSA_STALL_MOVE     2'h1
`define PSA_STALL_OTHER    2'h2
`define PSA_TABLE_WRITE_OP_CYCLES   2'h2
`define PSA_OP_ROW         4'h1
`define PSA_OP_PAGE_ERASE  4'h2
`define PSA_OP_WORD        4'h3
`define PSA_PROG_CYCLES    16'h0040
`define PSA_ERASE_CYCLES   16'h0080

`endif

/* design/psa_pkg.sv */
/*
 * Types of the program space access unit.
 * Assumes psa_params.svh on the include path.
 */
`include "psa_params.svh"

package psa_pkg;

	typedef enum logic [1:0] {
		ACC_NONE,
		ACC_READ,
		ACC_WRITE
	} table_acc_e;

	typedef struct packed {
		logic        valid;
		logic        high;
		logic        write;
		logic        byte_mode;
		logic [15:0] ea;
		logic [15:0] wdata;
	} table_req_s;

	typedef struct packed {
		logic        valid;
		logic        move_instr;
		logic        in_repeat;
		logic        rep_first;
		logic        rep_last;
		logic        rep_irq;
		logic [15:0] ea;
	} data_req_s;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} read_rsp_s;

	typedef struct packed {
		logic        rd;
		logic [23:0] addr;
	} pmem_rd_s;

	typedef struct packed {
		logic        start;
		logic        erase;
		logic [3:0]  op;
		logic [23:0] addr;
	} flash_cmd_s;

endpackage

/* design/program_space_access_unit.sv */
/*
 * Program space access unit: table reads and writes into the 24-bit
 * program memory, remapping of upper data space into a program page,
 * row holding latches and the start of a flash program or erase.
 * Assumes a program memory read port answering in the same cycle, a flash
 * macro that reports completion on flash_done_i, and a core that honours
 * stall_o. The core control, page, flash control and key registers are
 * written by the core over a small register port.
 */
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "psa_params.svh"

module program_space_access_unit (
	// Clock and reset
	input  wire logic                 mclk_i,
	input  wire logic                 rst_n_i,
	// Register port
	input  wire logic [1:0]           reg_addr_i,
	input  wire logic [15:0]          reg_wdata_i,
	input  wire logic                 reg_wr_i,
	input  wire logic                 reg_rd_i,
	output logic      [15:0]          reg_rdata_o,
	// Core table and data requests
	input  wire psa_pkg::table_req_s  table_req_i,
	input  wire psa_pkg::data_req_s   data_req_i,
	output psa_pkg::read_rsp_s        read_rsp_o,
	output logic                      stall_o,
	// Program memory read port
	output psa_pkg::pmem_rd_s         pmem_rd_o,
	input  wire logic [23:0]          pmem_rdata_i,
	// Flash macro
	output psa_pkg::flash_cmd_s       flash_cmd_o,
	output logic      [23:0]          latch_rdata_o,
	input  wire logic [5:0]           latch_idx_i,
	input  wire logic                 flash_done_i
);

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [1:0] REG_CORE  = 2'h0;
	localparam logic [1:0] REG_PAGES = 2'h1;
	localparam logic [1:0] REG_FCTRL = 2'h2;
	localparam logic [1:0] REG_KEY   = 2'h3;

	logic [15:0] core_control_reg_q;
	logic [7:0]  table_page_select_q;
	logic [7:0]  visibility_page_select_q;
	logic        start_q;
	logic        wr_enable_q;
	logic        seq_err_q;
	logic        erase_q;
	logic [3:0]  op_q;
	logic [1:0]  key_state_q;
	logic [23:0] flash_addr_q;

	logic visibility_enable;
	logic in_config;
	logic key_ok;
	logic start_req;
	logic busy;

	assign visibility_enable = core_control_reg_q[`PSA_VIS_EN_BIT];
	assign in_config         = table_page_select_q[`PSA_CFG_BIT];
	assign key_ok            = (key_state_q == 2'h2);
	assign start_req         = reg_wr_i && (reg_addr_i == REG_FCTRL) && reg_wdata_i[`PSA_START_BIT] && !start_q;

	// ----------------------------------------
	// Core control and page registers
	// ----------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			core_control_reg_q       <= 16'h0000;
			table_page_select_q      <= 8'h00;
			visibility_page_select_q <= 8'h00;
		end else if (reg_wr_i) begin
			if (reg_addr_i == REG_CORE) begin
				core_control_reg_q <= reg_wdata_i;
			end
			if (reg_addr_i == REG_PAGES) begin
				table_page_select_q      <= reg_wdata_i[7:0];
				visibility_page_select_q <= reg_wdata_i[15:8];
			end
		end
	end

	// ----------------------------------------
	// Unlock key sequence
	// ----------------------------------------
	// Zero idle, one after the first key, two when armed. Any other
	// register write breaks the sequence.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			key_state_q <= 2'h0;
		end else if (reg_wr_i) begin
			if (reg_addr_i == REG_KEY) begin
				if (reg_wdata_i[7:0] == `PSA_KEY_FIRST) begin
					key_state_q <= 2'h1;
				end else if (reg_wdata_i[7:0] == `PSA_KEY_SECOND && key_state_q == 2'h1) begin
					key_state_q <= 2'h2;
				end else begin
					key_state_q <= 2'h0;
				end
			end else begin
				key_state_q <= 2'h0;
			end
		end
	end

	// ----------------------------------------
	// Flash control
	// ----------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			start_q      <= 1'b0;
			wr_enable_q  <= 1'b0;
			seq_err_q    <= 1'b0;
			erase_q      <= 1'b0;
			op_q         <= 4'h0;
			flash_addr_q <= 24'h000000;
		end else begin
			if (start_q && flash_done_i) begin
				start_q <= 1'b0;
			end
			if (reg_wr_i && reg_addr_i == REG_FCTRL && !start_q) begin
				wr_enable_q <= reg_wdata_i[14];
				erase_q     <= reg_wdata_i[6];
				op_q        <= reg_wdata_i[3:0];
				seq_err_q   <= reg_wdata_i[13];
				if (start_req) begin
					if (key_ok && reg_wdata_i[14]) begin
						start_q <= 1'b1;
					end else begin
						seq_err_q <= 1'b1;
					end
				end
			end
			// Erase and row commands take the full, unaligned address of the last table write outside the configuration page: page and offset
			if (table_req_i.valid && table_req_i.write && !in_config) begin
				flash_addr_q <= {table_page_select_q, table_req_i.ea};
			end
		end
	end

	assign busy = start_q;

	always_comb begin
		flash_cmd_o.start = start_q;
		flash_cmd_o.erase = erase_q;
		flash_cmd_o.op    = op_q;
		flash_cmd_o.addr  = flash_addr_q;
	end

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				REG_CORE:  reg_rdata_o <= core_control_reg_q;
				REG_PAGES: reg_rdata_o <= {visibility_page_select_q, table_page_select_q};
				REG_FCTRL: reg_rdata_o <= {start_q, wr_enable_q, seq_err_q, 6'h00, erase_q, 2'h0, op_q};
				default:   reg_rdata_o <= 16'h0000;
			endcase
		end else begin
			reg_rdata_o <= 16'h0000;
		end
	end

	// ----------------------------------------
	// Holding latches
	// ----------------------------------------
	// Word index within the row: two address units per program word.
	logic [23:0] latch_q [`PSA_ROW_WORDS];
	logic [5:0]  wr_idx;
	logic        latch_wr;

	assign wr_idx   = table_req_i.ea[6:1];
	assign latch_wr = table_req_i.valid && table_req_i.write && !in_config && !stall_o;

	genvar gi;
	generate
		for (gi = 0; gi < `PSA_ROW_WORDS; gi++) begin : g_latch
			// Latches keep no reset value, as in the array they stand for
			always_ff @(posedge mclk_i) begin
				if (latch_wr && wr_idx == gi) begin
					if (table_req_i.high) begin
						if (!table_req_i.byte_mode || !table_req_i.ea[0]) begin
							latch_q[gi][23:16] <= table_req_i.wdata[7:0];
						end
					end else if (!table_req_i.byte_mode) begin
						latch_q[gi][15:0] <= table_req_i.wdata;
					end else if (table_req_i.ea[0]) begin
						latch_q[gi][15:8] <= table_req_i.wdata[7:0];
					end else begin
						latch_q[gi][7:0] <= table_req_i.wdata[7:0];
					end
				end
			end
		end
	endgenerate

	assign latch_rdata_o = latch_q[latch_idx_i];

	// ----------------------------------------
	// Access sequencing and stall
	// ----------------------------------------
	logic       remap;
	logic [1:0] extra;
	logic [1:0] stall_cnt_q;
	logic       req_new;
	logic       paid_q;

	// Table accesses take priority and suspend the remap window
	assign remap = data_req_i.valid && data_req_i.ea[`PSA_REMAP_BIT] && visibility_enable
		&& !table_req_i.valid;

	always_comb begin
		if (table_req_i.valid && table_req_i.write) begin
			extra = `PSA_TABLE_WRITE_OP_CYCLES - 2'h1;
		end else if (!remap) begin
			extra = 2'h0;
		end else if (data_req_i.in_repeat) begin
			extra = (data_req_i.rep_first || data_req_i.rep_last || data_req_i.rep_irq)
				? `PSA_STALL_OTHER : 2'h0;
		end else begin
			extra = data_req_i.move_instr ? `PSA_STALL_MOVE : `PSA_STALL_OTHER;
		end
	end

	assign req_new = (stall_cnt_q == 2'h0) && !busy;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stall_cnt_q <= 2'h0;
		end else if (stall_cnt_q != 2'h0) begin
			stall_cnt_q <= stall_cnt_q - 2'h1;
		end else if (req_new && !paid_q && extra != 2'h0) begin
			stall_cnt_q <= extra - 2'h1;
		end
	end

	// Marks a held request whose extra cycles are already served
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			paid_q <= 1'b0;
		end else if (!stall_o) begin
			paid_q <= 1'b0;
		end else if (req_new && extra != 2'h0) begin
			paid_q <= 1'b1;
		end
	end

	// Core holds the request while stalled, and during a flash operation
	assign stall_o = (stall_cnt_q != 2'h0) || busy || (req_new && extra != 2'h0 && !paid_q);

	// ----------------------------------------
	// Program memory reads and read data
	// ----------------------------------------
	logic [23:0] rd_addr;
	logic        rd_en;

	always_comb begin
		if (table_req_i.valid) begin
			rd_addr = {table_page_select_q, table_req_i.ea};
		end else begin
			rd_addr = {1'b0, visibility_page_select_q, data_req_i.ea[14:0]};
		end
		rd_en = (table_req_i.valid && !table_req_i.write) || remap;
	end

	always_comb begin
		pmem_rd_o.rd   = rd_en;
		pmem_rd_o.addr = rd_addr;
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			read_rsp_o <= '0;
		end else begin
			read_rsp_o.valid <= rd_en && !stall_o;
			read_rsp_o.data  <= 16'h0000;
			if (rd_en && !stall_o) begin
				if (!table_req_i.valid) begin
					read_rsp_o.data <= pmem_rdata_i[15:0];
				end else if (table_req_i.high) begin
					if (table_req_i.byte_mode && table_req_i.ea[0]) begin
						read_rsp_o.data <= 16'h0000;
					end else begin
						read_rsp_o.data <= {8'h00, pmem_rdata_i[23:16]};
					end
				end else if (!table_req_i.byte_mode) begin
					read_rsp_o.data <= pmem_rdata_i[15:0];
				end else begin
					read_rsp_o.data <= {8'h00, table_req_i.ea[0] ? pmem_rdata_i[15:8] : pmem_rdata_i[7:0]};
				end
			end
		end
	end

endmodule

/* tb/psa_props.sv */
/*
 * Checker for the program space access unit.
 * Sees only the unit's ports; bound from the bench top file.
 */
`timescale 1ns/100ps
module psa_props (
	// Clock and reset
	input wire logic                mclk_i,
	input wire logic                rst_n_i,
	// Register port
	input wire logic [1:0]          reg_addr_i,
	input wire logic [15:0]         reg_wdata_i,
	input wire logic                reg_wr_i,
	// Core and memory side
	input wire psa_pkg::table_req_s table_req_i,
	input wire psa_pkg::data_req_s  data_req_i,
	input wire psa_pkg::read_rsp_s  read_rsp_o,
	input wire logic                stall_o,
	input wire psa_pkg::pmem_rd_s   pmem_rd_o,
	input wire logic [23:0]         pmem_rdata_i,
	input wire psa_pkg::flash_cmd_s flash_cmd_o,
	input wire logic                flash_done_i
);
	logic [7:0]  tp_q;
	logic [7:0]  vp_q;
	logic        ven_q;
	wire  [15:0] plo = pmem_rdata_i[15:0];
	wire         trd = table_req_i.valid && !table_req_i.write && !stall_o;
	wire         remap = data_req_i.valid && data_req_i.ea[15] && ven_q && !table_req_i.valid;
	wire         redge = data_req_i.rep_first || data_req_i.rep_last || data_req_i.rep_irq;
	wire         k55 = reg_wr_i && reg_addr_i == 2'h3 && reg_wdata_i[7:0] == 8'h55;
	wire         kaa = reg_wr_i && reg_addr_i == 2'h3 && reg_wdata_i[7:0] == 8'hAA;
	wire         go = reg_wr_i && reg_addr_i == 2'h2 && reg_wdata_i[15];

	// Shadow copies of the page and visibility settings
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			{vp_q, tp_q} <= 16'h0000;
		else if (reg_wr_i && reg_addr_i == 2'h1)
			{vp_q, tp_q} <= reg_wdata_i;
	end
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			ven_q <= 1'b0;
		else if (reg_wr_i && reg_addr_i == 2'h0)
			ven_q <= reg_wdata_i[2];
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	sequence stall_one;
		stall_o ##1 !stall_o;
	endsequence
	sequence stall_two;
		stall_o [*2] ##1 !stall_o;
	endsequence

	chk_tbl_addr: assert property (
		table_req_i.valid && !table_req_i.write |-> pmem_rd_o.rd && pmem_rd_o.addr == {tp_q, table_req_i.ea})
		else $error("table address wrong");
	chk_low_word: assert property (
		trd && !table_req_i.high && !table_req_i.byte_mode |=> read_rsp_o.valid && read_rsp_o.data == $past(plo))
		else $error("low word read wrong");
	chk_high_zero: assert property (
		trd && table_req_i.high |=> read_rsp_o.valid && read_rsp_o.data[15:8] == 8'h00)
		else $error("high read upper byte not zero");
	chk_phantom_byte: assert property (
		trd && table_req_i.high && table_req_i.byte_mode && table_req_i.ea[0] |=> read_rsp_o.data == 16'h0000)
		else $error("phantom byte not zero");
	chk_remap_addr: assert property (
		remap && !stall_o |-> pmem_rd_o.rd && pmem_rd_o.addr == {1'b0, vp_q, data_req_i.ea[14:0]})
		else $error("remap address wrong");
	chk_remap_data: assert property (
		remap && !stall_o |=> read_rsp_o.valid && read_rsp_o.data == $past(plo))
		else $error("remap data wrong");
	chk_plain_stall: assert property (
		$rose(remap) && !data_req_i.in_repeat |-> if (data_req_i.move_instr) stall_one else stall_two)
		else $error("remap stall outside repeat wrong");
	chk_rep_edge: assert property (
		$rose(remap) && data_req_i.in_repeat && redge |-> stall_two)
		else $error("repeat edge stall wrong");
	chk_rep_fast: assert property (
		remap && data_req_i.in_repeat && !redge |-> !stall_o)
		else $error("repeat iteration stalled");
	chk_tbl_wr_two: assert property (
		$rose(table_req_i.valid && table_req_i.write) |-> stall_one)
		else $error("latch load not two cycles");
	chk_start_clear: assert property (
		flash_cmd_o.start && flash_done_i |=> !flash_cmd_o.start)
		else $error("start stayed after done");
	chk_key_needed: assert property (
		$rose(flash_cmd_o.start) |-> $past(go) && $past(kaa, 2) && $past(k55, 3))
		else $error("start without key sequence");
endmodule

/* tb/pmem_model.sv */
/*
 * Program memory and flash macro facing the unit.
 * Shares the unit's clock; completion comes DONE_DLY cycles after start.
 */
`timescale 1ns/100ps
module pmem_model #(
	parameter int DONE_DLY = 5
) (
	input  wire logic                mclk_i,
	input  wire logic                rst_n_i,
	input  wire psa_pkg::pmem_rd_s   pmem_rd_i,
	input  wire psa_pkg::flash_cmd_s flash_cmd_i,
	output logic [23:0]              pmem_rdata_o,
	output logic                     flash_done_o
);
	logic [23:0] last_q;
	logic [7:0]  cnt_q;

	// Idle read port flips every cycle so no stale word looks valid
	assign pmem_rdata_o = pmem_rd_i.rd ? {pmem_rd_i.addr[7:0] ^ 8'h5A, pmem_rd_i.addr[23:8]} : ~last_q;
	assign flash_done_o = flash_cmd_i.start && cnt_q == DONE_DLY[7:0];
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			last_q <= 24'h000000;
		else
			last_q <= pmem_rdata_o;
	end
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i || !flash_cmd_i.start || flash_done_o)
			cnt_q <= 8'h00;
		else
			cnt_q <= cnt_q + 8'h01;
	end
endmodule

/* tb/program_space_access_unit_bench.sv */
/*
 * Self-checking bench of the program space access unit.
 * Assumes the design, its package and the two bench modules compiled first.
 */
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module program_space_access_unit_bench;
	logic                mclk_i;
	logic                rst_n_i;
	logic                we;
	logic                re;
	logic                done;
	logic                stall;
	logic [1:0]          ra;
	logic [15:0]         wd;
	logic [15:0]         rdq;
	logic [5:0]          li;
	logic [23:0]         pd;
	logic [23:0]         lat;
	psa_pkg::table_req_s tq;
	psa_pkg::data_req_s  dq;
	psa_pkg::read_rsp_s  rsp;
	psa_pkg::pmem_rd_s   prd;
	psa_pkg::flash_cmd_s fc;
	int                  miscompares;
	int                  n_checks;
	int                  cyc;

	program_space_access_unit i_program_space_access_unit (.mclk_i, .rst_n_i, .reg_addr_i(ra), .reg_wdata_i(wd),
		.reg_wr_i(we), .reg_rd_i(re), .reg_rdata_o(rdq), .table_req_i(tq), .data_req_i(dq), .read_rsp_o(rsp),
		.stall_o(stall), .pmem_rd_o(prd), .pmem_rdata_i(pd), .flash_cmd_o(fc), .latch_rdata_o(lat),
		.latch_idx_i(li), .flash_done_i(done));
	pmem_model i_pmem_model (.mclk_i, .rst_n_i, .pmem_rd_i(prd), .flash_cmd_i(fc), .pmem_rdata_o(pd),
		.flash_done_o(done));

	always #4 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 4000) begin
			miscompares++;
			give_verdict();
		end
	end

	function automatic logic [23:0] pw(input logic [23:0] a);
		return {a[7:0] ^ 8'h5A, a[23:8]};
	endfunction

	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [1:0] a, input logic [15:0] d, input bit last);
		if (!we) @(posedge mclk_i);
		ra <= a;
		wd <= d;
		we <= 1'b1;
		@(posedge mclk_i);
		if (last) we <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [15:0] q);
		@(posedge mclk_i);
		ra <= a;
		re <= 1'b1;
		@(posedge mclk_i);
		re <= 1'b0;
		@(negedge mclk_i);
		q = rdq;
	endtask
	task automatic xfer(input psa_pkg::table_req_s t, input psa_pkg::data_req_s d, output int ns,
		output logic [15:0] q);
		ns = 0;
		@(posedge mclk_i);
		tq <= t;
		dq <= d;
		@(negedge mclk_i);
		while (stall === 1'b1 && ns < 9) begin
			ns++;
			@(negedge mclk_i);
		end
		@(posedge mclk_i);
		tq <= '0;
		dq <= '0;
		@(negedge mclk_i);
		q = (rsp.valid === 1'b1) ? rsp.data : 16'hXXXX;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_table_rd;
		logic [23:0] p;
		logic [15:0] q;
		logic [15:0] e;
		logic [2:0]  i;
		int          ns;
		wr(2'h1, 16'h0012, 1'b1);
		for (int k = 0; k < 8; k++) begin
			i = k[2:0];
			p = pw({8'h12, 15'h1A2B, i[0]});
			e = i[2] ? ((i[1] && i[0]) ? 16'h0000 : {8'h00, p[23:16]}) :
				!i[1] ? p[15:0] : {8'h00, i[0] ? p[15:8] : p[7:0]};
			xfer({1'b1, i[2], 1'b0, i[1], 15'h1A2B, i[0], 16'h0000}, '0, ns, q);
			`CHK(q, e)
			`CHK(ns, 0)
		end
		$display("table read test done");
	endtask

	task automatic t_remap;
		logic [4:0]  cs [6] = '{5'h10, 5'h00, 5'h18, 5'h0C, 5'h0A, 5'h09};
		int          es [6] = '{1, 2, 0, 2, 2, 2};
		logic [23:0] p;
		logic [15:0] q;
		int          ns;
		p = pw({1'b0, 8'hC3, 15'h36A5});
		wr(2'h0, 16'h0004, 1'b0);
		wr(2'h1, 16'hC312, 1'b1);
		for (int k = 0; k < 6; k++) begin
			xfer('0, {1'b1, cs[k], 16'hB6A5}, ns, q);
			`CHK(ns, es[k])
			`CHK(q, p[15:0])
		end
		p = pw({8'h12, 16'h8044});
		xfer({4'h8, 16'h8044, 16'h0000}, {1'b1, 5'h00, 16'h8044}, ns, q);
		`CHK(q, p[15:0])
		wr(2'h0, 16'h0000, 1'b1);
		xfer('0, {1'b1, 5'h00, 16'hB6A5}, ns, q);
		`CHK(ns, 0)
		$display("remap test done");
	endtask

	task automatic t_latch;
		logic [23:0] p;
		logic [15:0] q;
		int          ns;
		p = pw({8'h80, 16'h0010});
		wr(2'h1, 16'h0000, 1'b1);
		xfer({4'hA, 16'h0010, 16'h1234}, '0, ns, q);
		`CHK(ns, 1)
		xfer({4'hE, 16'h0010, 16'h00AB}, '0, ns, q);
		xfer({4'hA, 16'h0010, 16'h5678}, '0, ns, q);
		xfer({4'hE, 16'h007E, 16'h00FF}, '0, ns, q);
		xfer({4'hA, 16'h007E, 16'hFFFF}, '0, ns, q);
		wr(2'h1, 16'h0080, 1'b1);
		xfer({4'hA, 16'h0010, 16'h0BAD}, '0, ns, q);
		xfer({4'h8, 16'h0010, 16'h0000}, '0, ns, q);
		`CHK(q, p[15:0])
		@(posedge mclk_i);
		li <= 6'h08;
		@(negedge mclk_i);
		`CHK(lat, 24'hAB5678)
		@(posedge mclk_i);
		li <= 6'h3F;
		@(negedge mclk_i);
		`CHK(lat, 24'hFFFFFF)
		$display("latch test done");
	endtask

	task automatic t_flash;
		logic [15:0] v [3] = '{16'h4001, 16'h4042, 16'h4003};
		logic [15:0] q;
		int          n;
		for (int k = 0; k < 3; k++) begin
			wr(2'h3, 16'h0055, 1'b0);
			wr(2'h3, 16'h00AA, 1'b0);
			wr(2'h2, v[k] | 16'h8000, 1'b1);
			n = 0;
			while (fc.start !== 1'b1 && n < 20) begin
				n++;
				@(negedge mclk_i);
			end
			`CHK(fc.op, v[k][3:0])
			`CHK(fc.erase, v[k][6])
			`CHK(fc.addr, 24'h00007E)
			while (fc.start === 1'b1 && n < 40) begin
				n++;
				@(negedge mclk_i);
			end
			rd(2'h2, q);
			`CHK(q, v[k])
		end
		wr(2'h3, 16'h0055, 1'b0);
		wr(2'h2, 16'hC001, 1'b1);
		repeat (4) @(negedge mclk_i);
		`CHK(fc.start, 1'b0)
		rd(2'h2, q);
		`CHK(q[15:13], 3'b011)
		$display("flash start test done");
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		{mclk_i, rst_n_i, we, re, ra, wd, li} = '0;
		tq = '0;
		dq = '0;
		{miscompares, n_checks, cyc} = '0;
		repeat (20) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		t_table_rd();
		t_remap();
		t_latch();
		t_flash();
		give_verdict();
	end
endmodule

bind program_space_access_unit psa_props i_psa_props (.mclk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
	.table_req_i, .data_req_i, .read_rsp_o, .stall_o, .pmem_rd_o, .pmem_rdata_i, .flash_cmd_o, .flash_done_i);
